// ==== logic/mass_supply_sequencer.sv ====
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Mirror array supply sequencer (controller side)
// -----------------------------------------------------------------------------
module mass_supply_sequencer #(
  parameter int OFFSET_TO_BIAS_CYCLES = mass_pkg::OFFSET_TO_BIAS_NOM_CYCLES,
  parameter int OFFSET_TO_BIAS_MIN = mass_pkg::OFFSET_TO_BIAS_MIN_CYCLES,
  parameter int HOLD_CYCLES = mass_pkg::POWER_GOOD_HOLD_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic powerUpReq,
  input wire logic powerDownReq,
  input wire logic powerLoss,
  input wire logic outputEnableResetN,
  input wire logic coreSupplyGood,
  input wire logic offsetPowerGood,
  input wire logic highSupplyDischarged,
  input wire logic parkDone,
  output logic coreSupplyEn,
  output logic interfaceSupplyEn,
  output logic offsetSupplyEn,
  output logic biasSupplyEn,
  output logic mirrorResetSupplyEn,
  output logic logicInputEn,
  output logic powerDownN,
  output logic parkDoneOutputEnableN,
  output logic globalBiasCmd,
  output logic parkReq,
  output logic emergencyActive,
  output logic seqIdle
);
  import mass_pkg::*;

  mass_state_t seqState_reg;
  mass_state_t seqState_next;
  logic timerStart;
  logic [DELAY_W-1:0] timerLoad;
  logic timerExpired;
  logic parkSeen_reg;
  logic [DELAY_W-1:0] offsetGoodCount_reg;

  // ---------------------------------------------------------------------------
  // State helpers
  // ---------------------------------------------------------------------------
  function automatic logic mass_offset_on(input mass_state_t s);
    return (s == ST_OFFSET_UP) || (s == ST_BIAS_WAIT) || (s == ST_BIAS_UP) ||
           (s == ST_GLOBAL_BIAS) || (s == ST_RUN) || (s == ST_PARK) ||
           (s == ST_EPARK) || (s == ST_EOFF);
  endfunction

  function automatic logic mass_bias_on(input mass_state_t s);
    return (s == ST_BIAS_UP) || (s == ST_GLOBAL_BIAS) || (s == ST_RUN) || (s == ST_PARK);
  endfunction

  // ---------------------------------------------------------------------------
  // Sequencing state machine
  // ---------------------------------------------------------------------------
  // Next state; power loss outranks every other request once offset is applied.
  always_comb begin
    seqState_next = seqState_reg;
    case (seqState_reg)
      ST_OFF: begin
        seqState_next = (powerUpReq && outputEnableResetN) ? ST_CORE_UP : ST_OFF;
      end
      ST_CORE_UP: begin
        if (powerLoss || powerDownReq) begin
          seqState_next = ST_OFF;
        end else if (coreSupplyGood) begin
          seqState_next = ST_OFFSET_UP;
        end
      end
      ST_OFFSET_UP: begin
        if (powerLoss) begin
          seqState_next = ST_EPARK;
        end else if (offsetPowerGood) begin
          seqState_next = ST_BIAS_WAIT;
        end
      end
      ST_BIAS_WAIT: begin
        if (powerLoss) begin
          seqState_next = ST_EPARK;
        end else if (!offsetPowerGood) begin
          seqState_next = ST_OFFSET_UP; // Restart the wait if offset sags.
        end else if (timerExpired) begin
          seqState_next = ST_BIAS_UP;
        end
      end
      ST_BIAS_UP: begin
        seqState_next = powerLoss ? ST_EPARK : ST_GLOBAL_BIAS;
      end
      ST_GLOBAL_BIAS: begin
        seqState_next = powerLoss ? ST_EPARK : ST_RUN;
      end
      ST_RUN: begin
        if (powerLoss) begin
          seqState_next = ST_EPARK;
        end else if (powerDownReq) begin
          seqState_next = ST_PARK;
        end
      end
      ST_PARK: begin
        if (powerLoss) begin
          seqState_next = ST_EPARK;
        end else if (parkDone) begin
          seqState_next = ST_SUPPLY_OFF;
        end
      end
      ST_SUPPLY_OFF: begin
        seqState_next = timerExpired ? ST_DISCHARGE : ST_SUPPLY_OFF;
      end
      ST_DISCHARGE: begin
        seqState_next = highSupplyDischarged ? ST_OFF : ST_DISCHARGE;
      end
      ST_EPARK: begin
        seqState_next = parkDone ? ST_EOFF : ST_EPARK;
      end
      ST_EOFF: begin
        seqState_next = ST_DISCHARGE;
      end
      default: begin
        seqState_next = ST_OFF;
      end
    endcase
  end

  // State register.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      seqState_reg <= ST_OFF;
    end else begin
      seqState_reg <= seqState_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Delay timing
  // ---------------------------------------------------------------------------
  // One timer serves both waits because they never overlap in the sequence.
  assign timerStart = ((seqState_next == ST_BIAS_WAIT) && (seqState_reg != ST_BIAS_WAIT)) ||
                      ((seqState_next == ST_SUPPLY_OFF) && (seqState_reg != ST_SUPPLY_OFF));
  assign timerLoad = (seqState_next == ST_BIAS_WAIT) ? DELAY_W'(OFFSET_TO_BIAS_CYCLES) :
                     DELAY_W'(HOLD_CYCLES);

  mass_delay_timer #(
    .WIDTH(DELAY_W)
  ) u_delayTimer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .startPulse(timerStart),
    .loadCount(timerLoad),
    .expired(timerExpired)
  );

  // ---------------------------------------------------------------------------
  // Supply enables
  // ---------------------------------------------------------------------------
  // Enables follow the next state so each output comes straight from a flop.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      coreSupplyEn <= RST_SUPPLY_EN;
      interfaceSupplyEn <= RST_SUPPLY_EN;
      offsetSupplyEn <= RST_SUPPLY_EN;
      biasSupplyEn <= RST_SUPPLY_EN;
      mirrorResetSupplyEn <= RST_SUPPLY_EN;
    end else begin
      coreSupplyEn <= (seqState_next != ST_OFF);
      interfaceSupplyEn <= (seqState_next != ST_OFF);
      offsetSupplyEn <= mass_offset_on(seqState_next);
      // Bias and mirror-reset share one decision; no ordering is needed between them.
      biasSupplyEn <= mass_bias_on(seqState_next) ||
                      (biasSupplyEn && ((seqState_next == ST_EPARK) ||
                                        (seqState_next == ST_EOFF)));
      mirrorResetSupplyEn <= mass_bias_on(seqState_next) ||
                             (mirrorResetSupplyEn && ((seqState_next == ST_EPARK) ||
                                                      (seqState_next == ST_EOFF)));
    end
  end

  // ---------------------------------------------------------------------------
  // Device logic-level pins
  // ---------------------------------------------------------------------------
  // All logic pins stay low until the core rails are known good, which guards
  // against back-powering the device through its inputs.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      logicInputEn <= RST_LOGIC_LEVEL;
      powerDownN <= RST_LOGIC_LEVEL;
      parkDoneOutputEnableN <= RST_LOGIC_LEVEL;
    end else begin
      logicInputEn <= (seqState_next != ST_OFF) && (seqState_next != ST_CORE_UP);
      powerDownN <= mass_offset_on(seqState_next) && (seqState_next != ST_EOFF);
      // Output enable is low while mirrors are live and until core supplies are good; it is high during the
      // emergency cycle that precedes the offset drop.
      parkDoneOutputEnableN <= (seqState_next != ST_OFF) && (seqState_next != ST_CORE_UP) &&
                               (seqState_next != ST_RUN) && (seqState_next != ST_PARK) &&
                               (seqState_next != ST_EPARK);
    end
  end

  // ---------------------------------------------------------------------------
  // Commands and status
  // ---------------------------------------------------------------------------
  // Global bias is a single-cycle pulse; parking is a level held until done.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      globalBiasCmd <= 1'h0;
      parkReq <= 1'h0;
      emergencyActive <= 1'h0;
      seqIdle <= 1'h1;
    end else begin
      globalBiasCmd <= (seqState_next == ST_GLOBAL_BIAS);
      parkReq <= (seqState_next == ST_PARK) || (seqState_next == ST_EPARK);
      if (seqState_next == ST_EPARK) begin
        emergencyActive <= 1'h1;
      end else if (seqState_next == ST_OFF) begin
        emergencyActive <= 1'h0;
      end
      seqIdle <= (seqState_next == ST_OFF);
    end
  end

  // ---------------------------------------------------------------------------
  // Checking helpers
  // ---------------------------------------------------------------------------
  // Remembers that an orderly park completed before power-down.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      parkSeen_reg <= 1'h0;
    end else if ((seqState_reg == ST_PARK) && parkDone) begin
      parkSeen_reg <= 1'h1;
    end else if (seqState_next == ST_OFF) begin
      parkSeen_reg <= 1'h0;
    end
  end

  // Counts cycles of good offset with its enable on, saturating at full scale.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      offsetGoodCount_reg <= '0;
    end else if (!offsetSupplyEn || !offsetPowerGood) begin
      offsetGoodCount_reg <= '0;
    end else if (offsetGoodCount_reg != {DELAY_W{1'b1}}) begin
      offsetGoodCount_reg <= offsetGoodCount_reg + {{(DELAY_W-1){1'b0}}, 1'b1};
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  sequence s_normalOffsetOff;
    $fell(offsetSupplyEn) && !emergencyActive;
  endsequence
  sequence s_emergencyOffsetOff;
    $fell(offsetSupplyEn) && emergencyActive;
  endsequence
  sequence s_lossWhileLive;
    powerLoss && offsetSupplyEn && !emergencyActive;
  endsequence
  property p_coreBeforeOffset;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(offsetSupplyEn) |-> coreSupplyEn && interfaceSupplyEn && $past(coreSupplyGood);
  endproperty
  a_coreBeforeOffset: assert property (p_coreBeforeOffset)
    else $error("Offset supply enabled before core supplies settled.");
  property p_biasAfterDelay;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(biasSupplyEn) |-> offsetSupplyEn &&
                              (offsetGoodCount_reg >= DELAY_W'(OFFSET_TO_BIAS_MIN));
  endproperty
  a_biasAfterDelay: assert property (p_biasAfterDelay)
    else $error("Bias supply enabled too soon after offset good.");
  property p_biasWithMirrorReset;
    @(posedge core_clk) disable iff (!rst_n)
      $changed(biasSupplyEn) |-> biasSupplyEn == mirrorResetSupplyEn;
  endproperty
  a_biasWithMirrorReset: assert property (p_biasWithMirrorReset)
    else $error("Bias and mirror-reset supplies switched apart.");
  property p_logicLowUntilSettled;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(logicInputEn) |-> coreSupplyEn && $past(coreSupplyGood) && !$past(powerDownN);
  endproperty
  a_logicLowUntilSettled: assert property (p_logicLowUntilSettled)
    else $error("Logic inputs released before core supplies settled.");
  property p_coreHeldForDischarge;
    @(posedge core_clk) disable iff (!rst_n)
      $fell(coreSupplyEn) |-> !offsetSupplyEn && !biasSupplyEn && !mirrorResetSupplyEn &&
        ($past(highSupplyDischarged) || ($past(seqState_reg) == ST_CORE_UP));
  endproperty
  a_coreHeldForDischarge: assert property (p_coreHeldForDischarge)
    else $error("Core supply dropped before high supplies discharged.");
  property p_powerGoodHold;
    @(posedge core_clk) disable iff (!rst_n)
      s_normalOffsetOff |-> (coreSupplyEn && (seqState_reg == ST_SUPPLY_OFF)) [*2];
  endproperty
  a_powerGoodHold: assert property (p_powerGoodHold)
    else $error("Power-good hold window cut short after offset disable.");
  property p_enableAfterOer;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(coreSupplyEn) |-> $past(outputEnableResetN) && !offsetSupplyEn;
  endproperty
  a_enableAfterOer: assert property (p_enableAfterOer)
    else $error("Supplies enabled while output-enable reset was low.");
  property p_globalBiasPulse;
    @(posedge core_clk) disable iff (!rst_n)
      globalBiasCmd |-> biasSupplyEn && mirrorResetSupplyEn ##1 !globalBiasCmd;
  endproperty
  a_globalBiasPulse: assert property (p_globalBiasPulse)
    else $error("Global bias command issued without supplies or held too long.");
  property p_parkBeforePowerDown;
    @(posedge core_clk) disable iff (!rst_n)
      s_normalOffsetOff |-> parkSeen_reg && !powerDownN && !biasSupplyEn && !parkReq;
  endproperty
  a_parkBeforePowerDown: assert property (p_parkBeforePowerDown)
    else $error("Power-down entered before mirror park completed.");
  property p_emergencyPark;
    @(posedge core_clk) disable iff (!rst_n)
      s_lossWhileLive |=> parkReq && emergencyActive && offsetSupplyEn;
  endproperty
  a_emergencyPark: assert property (p_emergencyPark)
    else $error("Power loss did not start an emergency park.");
  property p_oezBeforeOffsetDrop;
    @(posedge core_clk) disable iff (!rst_n)
      s_emergencyOffsetOff |-> parkDoneOutputEnableN && $past(parkDoneOutputEnableN);
  endproperty
  a_oezBeforeOffsetDrop: assert property (p_oezBeforeOffsetDrop)
    else $error("Offset dropped before output enable went high in emergency.");
  property p_biasFromTimer;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(biasSupplyEn) |-> $past(timerExpired) && $past(seqState_reg) == ST_BIAS_WAIT;
  endproperty
  a_biasFromTimer: assert property (p_biasFromTimer)
    else $error("Bias enabled without the delay timer expiring.");
endmodule // mass_supply_sequencer

// ==== logic/mass_pkg.sv ====
package mass_pkg;

  // ---------------------------------------------------------------------------
  // Timing figures and their cycle counts
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int NS_PER_MS = 1000000;
  localparam int OFFSET_TO_BIAS_DELAY_MIN_MS = 1;
  localparam int OFFSET_TO_BIAS_DELAY_NOM_MS = 2;
  localparam int POWER_GOOD_HOLD_TIME_NS = 100;

  // A least time rounds up to whole cycles and never comes to less than one.
  function automatic int mass_cycles_ceil(input int timeNs);
    int cycles;
    cycles = (timeNs + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (cycles < 1) ? 1 : cycles;
  endfunction

  // The offset-to-bias wait is in milliseconds, so it runs to tens of thousands of cycles.
  localparam int OFFSET_TO_BIAS_MIN_CYCLES =
    mass_cycles_ceil(OFFSET_TO_BIAS_DELAY_MIN_MS * NS_PER_MS);
  localparam int OFFSET_TO_BIAS_NOM_CYCLES =
    mass_cycles_ceil(OFFSET_TO_BIAS_DELAY_NOM_MS * NS_PER_MS);
  localparam int POWER_GOOD_HOLD_CYCLES = mass_cycles_ceil(POWER_GOOD_HOLD_TIME_NS);

  // ---------------------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------------------
  localparam int DELAY_W = 16;
  localparam logic RST_SUPPLY_EN = 1'h0;
  localparam logic RST_LOGIC_LEVEL = 1'h0;

  // ---------------------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_OFF,
    ST_CORE_UP,
    ST_OFFSET_UP,
    ST_BIAS_WAIT,
    ST_BIAS_UP,
    ST_GLOBAL_BIAS,
    ST_RUN,
    ST_PARK,
    ST_SUPPLY_OFF,
    ST_DISCHARGE,
    ST_EPARK,
    ST_EOFF
  } mass_state_t;

endpackage

// ==== logic/mass_delay_timer.sv ====
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Down-counting delay timer
// -----------------------------------------------------------------------------
module mass_delay_timer #(
  parameter int WIDTH = mass_pkg::DELAY_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic startPulse,
  input wire logic [WIDTH-1:0] loadCount,
  output logic expired
);

  logic [WIDTH-1:0] count_reg;
  logic running_reg;

  // Expired rises loadCount cycles after the start edge and holds until restarted.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      running_reg <= 1'h0;
      expired <= 1'h0;
    end else if (startPulse) begin
      count_reg <= loadCount;
      running_reg <= 1'h1;
      expired <= 1'h0;
    end else if (running_reg) begin
      if (count_reg <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
        running_reg <= 1'h0;
        expired <= 1'h1;
      end else begin
        count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // mass_delay_timer

// ==== test/mass_device_model.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Supply chip and mirror device stand-in
// ---------------------------------------------------------------------------
module mass_device_model (
  input wire logic core_clk,
  input wire logic coreSupplyEn,
  input wire logic offsetSupplyEn,
  input wire logic biasSupplyEn,
  input wire logic mirrorResetSupplyEn,
  input wire logic parkReq,
  output logic coreSupplyGood,
  output logic offsetPowerGood,
  output logic highSupplyDischarged,
  output logic parkDone
);
  logic [2:0] coreRamp = 3'h0;
  logic [2:0] offRamp = 3'h0;
  logic [1:0] drainCnt = 2'h0;
  logic [1:0] parkCnt = 2'h0;

  // Rails take three cycles to settle, so the controller has to wait for good.
  always_ff @(posedge core_clk) begin
    coreRamp <= {coreRamp[1:0], coreSupplyEn};
    offRamp <= {offRamp[1:0], offsetSupplyEn};
  end
  assign coreSupplyGood = &coreRamp;
  // Power-good lingers two cycles after its enable drops.
  assign offsetPowerGood = offsetSupplyEn ? (&offRamp) : (offRamp[1:0] != 2'h0);

  // High rails bleed off slowly; bias and mirror-reset may fall in any order.
  always_ff @(posedge core_clk) begin
    if (offsetSupplyEn | biasSupplyEn | mirrorResetSupplyEn) begin
      drainCnt <= 2'h0;
    end else if (drainCnt != 2'h3) begin
      drainCnt <= drainCnt + 2'h1;
    end
  end
  assign highSupplyDischarged = (drainCnt == 2'h3);

  // The mirrors need a few cycles to park, which exposes a slow answer.
  always_ff @(posedge core_clk) begin
    if (!parkReq) begin
      parkCnt <= 2'h0;
    end else if (parkCnt != 2'h3) begin
      parkCnt <= parkCnt + 2'h1;
    end
  end
  assign parkDone = (parkCnt == 2'h3);
endmodule // mass_device_model

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  localparam int N_DLY = 8;
  logic core_clk, rst_n, powerUpReq, powerDownReq, powerLoss, outputEnableResetN;
  logic coreSupplyGood, offsetPowerGood, highSupplyDischarged, parkDone;
  logic coreSupplyEn, interfaceSupplyEn, offsetSupplyEn, biasSupplyEn, mirrorResetSupplyEn;
  logic logicInputEn, powerDownN, parkDoneOutputEnableN, globalBiasCmd, parkReq;
  logic emergencyActive, seqIdle, prevCore;
  int bad_count = 0;
  int cmp_count = 0;

  // ---------------------------------------------------------------------------
  // Design and far side
  // ---------------------------------------------------------------------------
  mass_supply_sequencer #(.OFFSET_TO_BIAS_CYCLES(N_DLY), .OFFSET_TO_BIAS_MIN(4)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .powerUpReq(powerUpReq),
    .powerDownReq(powerDownReq), .powerLoss(powerLoss),
    .outputEnableResetN(outputEnableResetN), .coreSupplyGood(coreSupplyGood),
    .offsetPowerGood(offsetPowerGood), .highSupplyDischarged(highSupplyDischarged),
    .parkDone(parkDone), .coreSupplyEn(coreSupplyEn), .interfaceSupplyEn(interfaceSupplyEn),
    .offsetSupplyEn(offsetSupplyEn), .biasSupplyEn(biasSupplyEn),
    .mirrorResetSupplyEn(mirrorResetSupplyEn), .logicInputEn(logicInputEn),
    .powerDownN(powerDownN), .parkDoneOutputEnableN(parkDoneOutputEnableN),
    .globalBiasCmd(globalBiasCmd), .parkReq(parkReq), .emergencyActive(emergencyActive),
    .seqIdle(seqIdle));
  mass_device_model model (
    .core_clk(core_clk), .coreSupplyEn(coreSupplyEn), .offsetSupplyEn(offsetSupplyEn),
    .biasSupplyEn(biasSupplyEn), .mirrorResetSupplyEn(mirrorResetSupplyEn),
    .parkReq(parkReq), .coreSupplyGood(coreSupplyGood), .offsetPowerGood(offsetPowerGood),
    .highSupplyDischarged(highSupplyDischarged), .parkDone(parkDone));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return biasSupplyEn;
      1: return parkReq;
      2: return seqIdle;
      3: return offsetSupplyEn;
      default: return offsetPowerGood;
    endcase
  endfunction

  // Waits at falling edges for a level, counting cycles; a hang counts as a mismatch.
  task automatic waitSel(input int sel, input logic val, output int n);
    n = 0;
    while (pick(sel) !== val && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 200) begin
      bad_count++;
      $display("[FAIL] t=%0t wait sel=%h", $time, sel);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Ordering watch on every cycle; catches a slip in any state, not only the ones probed.
  // It looks 1 ns after the falling edge so that a reset driven on that edge has settled.
  always @(negedge core_clk) begin
    #1;
    if (rst_n) begin
      chk(biasSupplyEn, mirrorResetSupplyEn);
      chk(coreSupplyEn, interfaceSupplyEn);
      if (biasSupplyEn === 1'b1) chk(offsetSupplyEn, 1);
      if (offsetSupplyEn === 1'b1) chk(coreSupplyEn, 1);
      if ((logicInputEn | powerDownN) === 1'b1) chk(coreSupplyGood, 1);
      if (prevCore === 1'b1 && coreSupplyEn === 1'b0) chk(highSupplyDischarged, 1);
    end
    prevCore = coreSupplyEn;
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Reset is driven low at a falling edge; every enable must be off one edge later.
  task automatic test_reset();
    rst_n = 1'b0;
    @(negedge core_clk);
    chk({coreSupplyEn, interfaceSupplyEn, offsetSupplyEn, biasSupplyEn, mirrorResetSupplyEn,
         logicInputEn, powerDownN, parkDoneOutputEnableN, globalBiasCmd, parkReq,
         emergencyActive, seqIdle}, 12'h001);
    rst_n = 1'b1;
    @(negedge core_clk);
    $display("test reset done");
  endtask

  // A power-up request while the output-enable reset is still low must be ignored.
  task automatic test_oe_gate();
    outputEnableResetN = 1'b0;
    powerUpReq = 1'b1;
    repeat (6) @(negedge core_clk);
    chk({coreSupplyEn, offsetSupplyEn, seqIdle}, 3'h1);
    powerUpReq = 1'b0;
    outputEnableResetN = 1'b1;
    @(negedge core_clk);
    $display("test oe_gate done");
  endtask

  task automatic test_power_up();
    int n;
    int pulses;
    powerUpReq = 1'b1;
    waitSel(3, 1'b1, n);
    powerUpReq = 1'b0;
    chk(coreSupplyGood, 1);
    chk(biasSupplyEn, 0);
    waitSel(4, 1'b1, n);
    waitSel(0, 1'b1, n);
    chk(n >= N_DLY, 1);
    pulses = 0;
    repeat (5) begin
      @(negedge core_clk);
      pulses += int'(globalBiasCmd === 1'b1);
    end
    chk(pulses, 1);
    chk({parkDoneOutputEnableN, powerDownN, logicInputEn}, 3'h3);
    $display("test power_up done");
  endtask

  task automatic test_shutdown();
    int n;
    powerDownReq = 1'b1;
    waitSel(1, 1'b1, n);
    powerDownReq = 1'b0;
    chk({offsetSupplyEn, biasSupplyEn, powerDownN}, 3'h7);
    waitSel(1, 1'b0, n);
    chk({offsetSupplyEn, biasSupplyEn, powerDownN}, 3'h0);
    chk(coreSupplyEn, 1);
    waitSel(2, 1'b1, n);
    chk({coreSupplyEn, logicInputEn, highSupplyDischarged}, 3'h1);
    $display("test shutdown done");
  endtask

  task automatic test_emergency();
    int n;
    powerLoss = 1'b1;
    waitSel(1, 1'b1, n);
    chk(emergencyActive, 1);
    chk(parkDoneOutputEnableN, 0);
    waitSel(1, 1'b0, n);
    chk({parkDoneOutputEnableN, offsetSupplyEn, offsetPowerGood}, 3'h7);
    @(negedge core_clk);
    chk({offsetSupplyEn, biasSupplyEn, coreSupplyEn}, 3'h1);
    powerLoss = 1'b0;
    waitSel(2, 1'b1, n);
    chk({emergencyActive, coreSupplyEn}, 2'h0);
    $display("test emergency done");
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    powerUpReq = 1'b0;
    powerDownReq = 1'b0;
    powerLoss = 1'b0;
    outputEnableResetN = 1'b1;
    repeat (2) @(negedge core_clk);
    test_reset();
    test_oe_gate();
    test_power_up();
    test_shutdown();
    test_power_up();
    test_emergency();
    // A second reset lands in the running state, with every supply on.
    test_power_up();
    test_reset();
    summarize();
  end

  // The tests need about a hundred cycles; thirty times that means a hang.
  initial begin
    #(3000 * 100);
    bad_count++;
    summarize();
  end
endmodule // tb_top
